// ### pkg/hpc_pkg.sv
package hpc_pkg;
    localparam int          DATA_W      = 8;
    localparam int          SEL_W       = 3;
    localparam int          PIN_W       = 12;
    // Shared pin positions inside the 12-bit pin vector
    localparam int          DATA_LSB    = 0;
    localparam int          SEL_LSB     = 8;
    localparam int          RW_BIT      = 11;
    // Synchronised strobe vector layout: pins, enable, ack
    localparam int          SYNC_W      = 14;
    localparam int          EN_BIT      = 12;
    localparam int          ACK_BIT     = 13;
    localparam logic [7:0]  DATA_RST    = 8'h00;
    localparam logic [2:0]  SEL_RST     = 3'h0;
    localparam logic [11:0] PIN_OUT_RST = 12'h000;
    // All pins undriven: active-low enables high
    localparam logic [11:0] OE_N_RST    = 12'hFFF;
    localparam logic [7:0]  DATA_OE_OFF = 8'hFF;
    localparam logic [7:0]  DATA_OE_ON  = 8'h00;
    localparam logic [13:0] SYNC_RST    = 14'h3FFF;

    typedef struct packed {
        logic              valid;
        logic [SEL_W-1:0]  sel;
        logic [DATA_W-1:0] data;
    } hpc_wr_t;
endpackage

// ### tb/hpc_host_model.sv
`timescale 1ns/10ps
module hpc_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe_n,
    input  wire logic [2:0] sel_out,
    input  wire logic [2:0] sel_oe_n,
    input  wire logic       rw_out,
    input  wire logic       rw_oe_n,
    output logic      [7:0] data_pin,
    output logic      [2:0] sel_pin,
    output logic            rw_pin,
    output logic            en_n,
    output logic            ack_n
);
    logic [7:0] drv = 8'h00;
    logic       drv_en = 1'b0;
    logic [7:0] last = 8'h00;
    logic [2:0] sel_drv = 3'h0;
    logic       rw_drv = 1'b0;
    initial ack_n = 1'b1;
    initial en_n = 1'b1;
    // Released bits toggle, so a stale byte never reads back as good
    assign data_pin = (~data_oe_n & data_out)
                    | (data_oe_n & (drv_en ? drv : ~last));
    assign sel_pin = (~sel_oe_n & sel_out) | (sel_oe_n & sel_drv);
    assign rw_pin = rw_oe_n ? rw_drv : rw_out;
    always @(posedge ref_clk) last <= data_pin;
    task access(input logic rw, input logic [2:0] a,
                input logic [7:0] d, output logic [15:0] seen);
        @(posedge ref_clk);
        #1;
        rw_drv = rw;
        sel_drv = a;
        drv = d;
        drv_en = ~rw;
        en_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        seen = {data_oe_n, data_pin};
        en_n = 1'b1;
        @(posedge ref_clk);
        #1;
        drv_en = 1'b0;
    endtask
endmodule // hpc_host_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic             ref_clk = 1'b0;
    logic             rst = 1'b1;
    logic             host_port_select = 1'b1;
    logic             dma_request = 1'b0;
    logic [7:0]       bus, d_out, d_oe_n, rd_data;
    logic [2:0]       a_pin, a_out, a_oe_n, reg_sel;
    logic             rw_pin, rw_out, rw_oe_n, en_n, ack_n, req_n, rd_done;
    logic [11:0]      gpio_out = 12'h000;
    logic [11:0]      gpio_dir = 12'h000;
    logic [11:0]      gpio_in;
    logic [15:0]      seen;
    hpc_pkg::hpc_wr_t wr, wr_seen;
    int               miscompares = 0;
    int               check_count = 0;
    int               wr_cnt = 0;
    int               rd_cnt = 0;

    always #10 ref_clk = ~ref_clk;
    assign rd_data = {reg_sel, 2'h2, ~reg_sel};

    hpc_host_port dut (.ref_clk(ref_clk), .rst(rst),
        .host_port_select(host_port_select), .host_data_bus_in(bus),
        .host_data_bus_out(d_out), .host_data_bus_oe_n(d_oe_n),
        .host_register_select_in(a_pin), .host_register_select_out(a_out),
        .host_register_select_oe_n(a_oe_n), .host_read_not_write_in(rw_pin),
        .host_read_not_write_out(rw_out), .host_read_not_write_oe_n(rw_oe_n),
        .host_enable_n(en_n), .host_ack_n(ack_n), .dma_request(dma_request),
        .host_request_n(req_n), .host_reg_sel(reg_sel),
        .host_reg_rd_data(rd_data), .host_reg_wr(wr),
        .host_reg_rd_done(rd_done), .gpio_out(gpio_out),
        .gpio_dir(gpio_dir), .gpio_in(gpio_in));

    hpc_host_model host (.ref_clk(ref_clk), .data_out(d_out),
        .data_oe_n(d_oe_n), .sel_out(a_out), .sel_oe_n(a_oe_n),
        .rw_out(rw_out), .rw_oe_n(rw_oe_n), .data_pin(bus),
        .sel_pin(a_pin), .rw_pin(rw_pin), .en_n(en_n), .ack_n(ack_n));

    always @(posedge ref_clk) begin
        if (wr.valid === 1'b1) begin
            wr_seen <= wr;
            wr_cnt++;
        end
        if (rd_done === 1'b1) rd_cnt++;
    end

    function automatic logic [7:0] rdv(input logic [2:0] a);
        return {a, 2'h2, ~a};
    endfunction

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task t_reset;
        tick(3);
        check({4'hF, rw_oe_n, a_oe_n, d_oe_n}, 16'hFFFF);
        check({4'h0, gpio_in}, 16'h0000);
        tick(2);
        rst = 1'b0;
        tick(2);
        check({8'h00, d_oe_n}, 16'h00FF);
    endtask

    task t_write;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            d = 8'h3C + 8'(i * 17);
            host.access(1'b0, 3'(i), d, seen);
            check(seen, {8'hFF, d});
            tick(5);
            check({4'h0, wr_seen}, {4'h1, 3'(i), d});
            check(16'(wr_cnt), 16'(i + 1));
        end
    endtask

    task t_read;
        for (int i = 7; i >= 0; i--) begin
            host.access(1'b1, 3'(i), 8'h00, seen);
            check(seen, {8'h00, rdv(3'(i))});
            tick(5);
            check({8'h00, d_oe_n}, 16'h00FF);
            check(16'(rd_cnt), 16'(8 - i));
            check(16'(wr_cnt), 16'h0008);
        end
    endtask

    task t_ack;
        host.ack_n = 1'b0;
        tick(5);
        check({8'h00, d_oe_n}, 16'h00FF);
        dma_request = 1'b1;
        tick(1);
        check({15'h0000, req_n}, 16'h0000);
        tick(4);
        check({d_oe_n, bus}, {8'h00, rdv(3'h0)});
        host.ack_n = 1'b1;
        dma_request = 1'b0;
        tick(4);
        check({7'h00, req_n, d_oe_n}, 16'h01FF);
    endtask

    task t_gpio;
        host_port_select = 1'b0;
        gpio_dir = 12'h93C;
        gpio_out = 12'h5A6;
        host.drv = 8'hC3;
        host.drv_en = 1'b1;
        host.sel_drv = 3'h5;
        host.rw_drv = 1'b1;
        host.en_n = 1'b0;
        tick(5);
        check({4'h0, rw_oe_n, a_oe_n, d_oe_n}, {4'h0, ~gpio_dir});
        check({4'h0, rw_out, a_out, d_out} & {4'h0, gpio_dir},
              {4'h0, gpio_out & gpio_dir});
        check({4'h0, gpio_in}, {4'h0, (gpio_out & gpio_dir)
              | (12'hDC3 & ~gpio_dir)});
        host.en_n = 1'b1;
        tick(6);
        check(16'(wr_cnt), 16'h0008);
        host_port_select = 1'b1;
        gpio_dir = 12'h000;
        host.drv_en = 1'b0;
    endtask

    task final_report;
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(20 * 4000);
        miscompares++;
        final_report;
    end

    initial begin
        t_reset;
        t_write;
        t_read;
        t_ack;
        t_gpio;
        final_report;
    end
endmodule // tb_top

// ### verilog/hpc_host_port.sv
`timescale 1ns/10ps
module hpc_host_port (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic                     host_port_select,
    input  wire logic [7:0]               host_data_bus_in,
    output logic      [7:0]               host_data_bus_out,
    output logic      [7:0]               host_data_bus_oe_n,
    input  wire logic [2:0]               host_register_select_in,
    output logic      [2:0]               host_register_select_out,
    output logic      [2:0]               host_register_select_oe_n,
    input  wire logic                     host_read_not_write_in,
    output logic                          host_read_not_write_out,
    output logic                          host_read_not_write_oe_n,
    input  wire logic                     host_enable_n,
    input  wire logic                     host_ack_n,
    input  wire logic                     dma_request,
    output logic                          host_request_n,
    output logic      [2:0]               host_reg_sel,
    input  wire logic [7:0]               host_reg_rd_data,
    output hpc_pkg::hpc_wr_t              host_reg_wr,
    output logic                          host_reg_rd_done,
    input  wire logic [11:0]              gpio_out,
    input  wire logic [11:0]              gpio_dir,
    output logic      [11:0]              gpio_in
);
    logic [hpc_pkg::SYNC_W-1:0] raw_in;
    logic [hpc_pkg::SYNC_W-1:0] sync_s;
    logic [hpc_pkg::PIN_W-1:0]  pin_s;
    logic [hpc_pkg::PIN_W-1:0]  pin_prev;
    logic                       en_prev;
    logic [7:0]                 data_s;
    logic [7:0]                 data_prev;
    logic [2:0]                 sel_s;
    logic [2:0]                 sel_prev;
    logic                       rw_s;
    logic                       rw_prev;
    logic                       en_s;
    logic                       ack_s;
    logic                       host_read;
    logic                       ack_read;
    logic                       drive_data;
    logic                       en_rise;
    logic [11:0]                next_pin_out;
    logic [11:0]                next_pin_oe_n;
    logic [7:0]                 next_data_out;
    logic [7:0]                 next_data_oe_n;
    hpc_pkg::hpc_wr_t           next_wr;

    assign raw_in = {host_ack_n, host_enable_n, host_read_not_write_in,
                     host_register_select_in, host_data_bus_in};

    hpc_sync #(
        .W       (hpc_pkg::SYNC_W),
        .RST_VAL (hpc_pkg::SYNC_RST)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (raw_in),
        .sync_out (sync_s)
    );

    assign pin_s  = sync_s[hpc_pkg::PIN_W-1:0];
    assign data_s = pin_s[hpc_pkg::DATA_LSB +: hpc_pkg::DATA_W];
    assign sel_s  = pin_s[hpc_pkg::SEL_LSB +: hpc_pkg::SEL_W];
    assign rw_s   = pin_s[hpc_pkg::RW_BIT];
    assign en_s   = sync_s[hpc_pkg::EN_BIT];
    assign ack_s  = sync_s[hpc_pkg::ACK_BIT];
    assign data_prev = pin_prev[hpc_pkg::DATA_LSB +: hpc_pkg::DATA_W];
    assign sel_prev  = pin_prev[hpc_pkg::SEL_LSB +: hpc_pkg::SEL_W];
    assign rw_prev   = pin_prev[hpc_pkg::RW_BIT];

    // read direction from enable and read/write
    assign host_read  = host_port_select & ~en_s & rw_s;
    assign ack_read   = host_port_select & ~ack_s & ~host_request_n;
    // undriven unless one of the two read cases holds
    assign drive_data = host_read | ack_read;
    // capture on the deasserting edge of enable
    assign en_rise    = host_port_select & en_s & ~en_prev;

    // addressed register data onto the bus
    assign next_data_out  = drive_data ? host_reg_rd_data : host_data_bus_out;
    assign next_data_oe_n = drive_data ? hpc_pkg::DATA_OE_ON
                                       : hpc_pkg::DATA_OE_OFF;

    // write delivery; sample taken one cycle before the rise
    // because the host may release the bus right after enable rises.
    // direction follows the read/write level held during enable
    assign next_wr.valid = en_rise & ~rw_prev;
    assign next_wr.sel   = sel_prev;
    assign next_wr.data  = data_prev;

    // general-purpose pin muxing, one slice per pin
    genvar gi;
    generate
        for (gi = 0; gi < hpc_pkg::PIN_W; gi++) begin : g_pin
            assign next_pin_out[gi]  = host_port_select ? 1'b0 : gpio_out[gi];
            assign next_pin_oe_n[gi] = host_port_select ? 1'b1
                                                        : ~gpio_dir[gi];
        end
    endgenerate

    // reset leaves every shared pin an undriven input
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_data_bus_out         <= hpc_pkg::DATA_RST;
            host_data_bus_oe_n        <= hpc_pkg::DATA_OE_OFF;
            host_register_select_out  <= hpc_pkg::SEL_RST;
            host_register_select_oe_n <= hpc_pkg::OE_N_RST[2:0];
            host_read_not_write_out   <= 1'b0;
            host_read_not_write_oe_n  <= 1'b1;
        end else begin
            host_data_bus_out         <= host_port_select ? next_data_out
                : next_pin_out[hpc_pkg::DATA_LSB +: hpc_pkg::DATA_W];
            host_data_bus_oe_n        <= host_port_select ? next_data_oe_n
                : next_pin_oe_n[hpc_pkg::DATA_LSB +: hpc_pkg::DATA_W];
            host_register_select_out  <=
                next_pin_out[hpc_pkg::SEL_LSB +: hpc_pkg::SEL_W];
            host_register_select_oe_n <=
                next_pin_oe_n[hpc_pkg::SEL_LSB +: hpc_pkg::SEL_W];
            host_read_not_write_out   <= next_pin_out[hpc_pkg::RW_BIT];
            host_read_not_write_oe_n  <= next_pin_oe_n[hpc_pkg::RW_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_prev         <= hpc_pkg::PIN_OUT_RST;
            en_prev          <= 1'b1;
            host_request_n   <= 1'b1;
            host_reg_sel     <= hpc_pkg::SEL_RST;
            host_reg_wr      <= '0;
            host_reg_rd_done <= 1'b0;
            gpio_in          <= hpc_pkg::PIN_OUT_RST;
        end else begin
            pin_prev         <= pin_s;
            en_prev          <= en_s;
            host_request_n   <= ~(host_port_select & dma_request);
            host_reg_sel     <= (host_port_select & ~en_s) ? sel_s
                                                           : host_reg_sel;
            host_reg_wr      <= next_wr;
            host_reg_rd_done <= en_rise & rw_prev;
            gpio_in          <= pin_s;
        end
    end

    sequence seq_host_read;
        host_port_select && !en_s && rw_s;
    endsequence

    sequence seq_host_idle;
        host_port_select && en_s && !(!ack_s && !host_request_n);
    endsequence

    sequence seq_write_rise;
        host_port_select && !en_s && !rw_s ##1 host_port_select && en_s;
    endsequence

    // Data undriven while enable is deasserted and no acknowledge read holds
    chk_data_idle_tristate: assert property (
        @(posedge ref_clk) disable iff (rst)
        seq_host_idle |=> host_data_bus_oe_n == hpc_pkg::DATA_OE_OFF)
        else $error("data bus driven while host enable idle");

    // Read access drives the bus
    chk_read_drives_bus: assert property (
        @(posedge ref_clk) disable iff (rst)
        seq_host_read |=> host_data_bus_oe_n == hpc_pkg::DATA_OE_ON)
        else $error("data bus not driven during read");

    // Write access keeps the bus an input
    chk_write_bus_input: assert property (
        @(posedge ref_clk) disable iff (rst)
        host_port_select && !en_s && !rw_s && ack_s
        |=> host_data_bus_oe_n == hpc_pkg::DATA_OE_OFF)
        else $error("data bus driven during write");

    // Acknowledge with request drives the bus
    chk_ack_drives_bus: assert property (
        @(posedge ref_clk) disable iff (rst)
        host_port_select && !ack_s && !host_request_n
        |=> host_data_bus_oe_n == hpc_pkg::DATA_OE_ON)
        else $error("data bus not driven on acknowledge");

    // Read data is the addressed register value
    chk_read_data_value: assert property (
        @(posedge ref_clk) disable iff (rst)
        seq_host_read |=> host_data_bus_out == $past(host_reg_rd_data))
        else $error("read data mismatch");

    // Write pulse carries the byte held before the rise
    chk_write_capture: assert property (
        @(posedge ref_clk) disable iff (rst)
        seq_write_rise
        |=> host_reg_wr.valid && host_reg_wr.data == $past(data_prev)
            && host_reg_wr.sel == $past(sel_prev))
        else $error("write capture wrong");

    // One write pulse per strobe, only after a synchronised rise
    chk_write_single: assert property (
        @(posedge ref_clk) disable iff (rst)
        host_reg_wr.valid |-> $past(en_s) && !$past(en_prev)
            && !$past(host_reg_wr.valid))
        else $error("write pulse without enable rise");

    // Register select follows the address pins
    chk_select_decode: assert property (
        @(posedge ref_clk) disable iff (rst)
        host_port_select && !en_s |=> host_reg_sel == $past(sel_s))
        else $error("register select not decoded");

    // Deselected data and read/write pins follow the general-purpose direction
    chk_gpio_direction: assert property (
        @(posedge ref_clk) disable iff (rst)
        !host_port_select |=> host_data_bus_oe_n == ~$past(gpio_dir[7:0])
            && host_read_not_write_oe_n == ~$past(gpio_dir[11]))
        else $error("general-purpose direction wrong");

    // Pin reaches logic only after two stages
    chk_sync_delay: assert property (
        @(posedge ref_clk) disable iff (rst)
        $past(rst, 3) == 1'b0 |-> pin_s == $past(raw_in[11:0], 2))
        else $error("synchroniser depth wrong");
endmodule // hpc_host_port

// ### verilog/hpc_sync.sv
`timescale 1ns/10ps
module hpc_sync #(
    parameter int                  W       = 1,
    parameter logic [W-1:0]        RST_VAL = '0
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [W-1:0]      async_in,
    output logic      [W-1:0]      sync_out
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta     <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // hpc_sync
